// ---- hdl/rng_pkg.sv ----
package rng_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFF_IRQ_DISABLE = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] OFF_OUTPUT_WORD = 8'h50;
    // control fields
    localparam int ENABLE_BIT = 0;
    localparam int KEY_LSB = 8;
    localparam logic [23:0] KEY_VALUE = 24'h524E47;
    // flag position in mask and status registers
    localparam int READY_BIT = 0;
    // reset values
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    // production period in clock cycles
    localparam int WORD_PERIOD = 84;
    // lfsr seed, arbitrary nonzero
    localparam logic [31:0] LFSR_SEED = 32'hACE1_2468;

    // one decoded bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } bus_req_s;
endpackage : rng_pkg

// ---- hdl/rng_word_source.sv ----
`timescale 1ns/1ps
// free-running scrambler; the word advances every cycle while run is high
module rng_word_source (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_run,
    output logic [31:0] o_word
);
    logic [31:0] lfsr_ff; // galois shift state
    logic [31:0] nxt_lfsr;

    // taps 32,22,2,1; a pseudo-random stand-in for the analog entropy cell
    always_comb begin
        nxt_lfsr = {1'b0, lfsr_ff[31:1]};
        if (lfsr_ff[0]) begin
            nxt_lfsr = nxt_lfsr ^ 32'h8020_0003;
        end
    end

    // state update
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            lfsr_ff <= rng_pkg::LFSR_SEED;
        end else if (i_run) begin
            lfsr_ff <= nxt_lfsr;
        end
    end

    assign o_word = lfsr_ff;
endmodule : rng_word_source

// ---- hdl/random_word_generator.sv ----
// Design decision made here: the APB register port.
`timescale 1ns/1ps
// How it works
// - new 32-bit word every 84 cycles
// - control bit 0 starts or stops production
// - ready flag set when word available
// - status read clears ready flag
// - flag zero when invalid or disabled
// - interrupt on new word if unmasked
// - status read drops the interrupt
// - enable register bit 0 unmasks
// - disable register bit 0 masks
// - mask register shows mask, resets zero
// - output register holds word, resets zero
module random_word_generator #(
    parameter int PERIOD = rng_pkg::WORD_PERIOD
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_irq
);
    localparam int CW = $clog2(PERIOD);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    rng_pkg::bus_req_s req; // access-phase request
    logic enable_ff; // generator running
    logic irq_en_ff; // data-ready interrupt unmasked
    logic ready_ff; // data-ready flag
    logic [CW-1:0] cnt_ff; // production cycle counter
    logic [31:0] word_ff; // output word
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic [31:0] src_word;
    logic word_done; // a fresh word is latched this cycle
    logic status_rd; // status register read completes
    logic key_ok;
    logic [31:0] nxt_prdata;
    logic nxt_err;

    // true when the offset maps to a known register
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == rng_pkg::OFF_CONTROL) || (a == rng_pkg::OFF_IRQ_ENABLE)
            || (a == rng_pkg::OFF_IRQ_DISABLE) || (a == rng_pkg::OFF_IRQ_MASK)
            || (a == rng_pkg::OFF_IRQ_STATUS) || (a == rng_pkg::OFF_OUTPUT_WORD);
    endfunction : is_mapped

    // one wait state: the access completes when pready_ff is seen high
    // upper address bits must be zero, so an aliased offset has no side effect
    always_comb begin
        req.wr = i_psel && i_penable && i_pwrite && pready_ff && (i_paddr[31:8] == '0);
        req.rd = i_psel && i_penable && !i_pwrite && pready_ff && (i_paddr[31:8] == '0);
        req.addr = i_paddr[7:0];
        req.wdata = i_pwdata;
    end

    assign key_ok = (req.wdata[31:rng_pkg::KEY_LSB] == rng_pkg::KEY_VALUE);
    assign status_rd = req.rd && (req.addr == rng_pkg::OFF_IRQ_STATUS);
    assign word_done = enable_ff && (cnt_ff == LAST);

    // entropy source runs only while enabled to save switching
    rng_word_source u_src (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_run(enable_ff),
        .o_word(src_word)
    );

    // pready pulses one cycle into each access phase
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= i_psel && i_penable && !pready_ff;
        end
    end

    // enable bit, key protected
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            enable_ff <= 1'b0;
        end else if (req.wr && req.addr == rng_pkg::OFF_CONTROL && key_ok) begin
            enable_ff <= req.wdata[rng_pkg::ENABLE_BIT];
        end
    end

    // period counter restarts whenever production is off
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || !enable_ff) begin
            cnt_ff <= '0;
        end else if (cnt_ff == LAST) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + CW'(1);
        end
    end

    // output word latch
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            word_ff <= rng_pkg::WORD_RESET;
        end else if (word_done) begin
            word_ff <= src_word;
        end
    end

    // ready flag: a new word wins over a same-cycle status read
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ready_ff <= 1'b0;
        end else if (word_done) begin
            ready_ff <= 1'b1;
        end else if (!enable_ff) begin
            ready_ff <= 1'b0;
        end else if (status_rd) begin
            ready_ff <= 1'b0;
        end
    end

    // interrupt mask; enable wins if both written at once (cannot happen on apb)
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            irq_en_ff <= 1'b0;
        end else if (req.wr && req.addr == rng_pkg::OFF_IRQ_ENABLE
                && req.wdata[rng_pkg::READY_BIT]) begin
            irq_en_ff <= 1'b1;
        end else if (req.wr && req.addr == rng_pkg::OFF_IRQ_DISABLE
                && req.wdata[rng_pkg::READY_BIT]) begin
            irq_en_ff <= 1'b0;
        end
    end

    // interrupt follows flag and mask, registered for a clean output
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            irq_ff <= 1'b0;
        end else if (word_done) begin
            irq_ff <= irq_en_ff;
        end else if (status_rd || !enable_ff) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= ready_ff && irq_en_ff;
        end
    end

    // read mux; write-only registers read zero
    always_comb begin
        nxt_prdata = '0;
        nxt_err = 1'b0;
        if (i_psel && i_penable && !pready_ff) begin
            if (!is_mapped(i_paddr[7:0]) || i_paddr[31:8] != '0) begin
                nxt_err = 1'b1; // unmapped answers with slverr
            end else if (!i_pwrite) begin
                case (i_paddr[7:0])
                    rng_pkg::OFF_IRQ_MASK: nxt_prdata[rng_pkg::READY_BIT] = irq_en_ff;
                    rng_pkg::OFF_IRQ_STATUS: nxt_prdata[rng_pkg::READY_BIT] = ready_ff;
                    rng_pkg::OFF_OUTPUT_WORD: nxt_prdata = word_ff;
                    default: nxt_prdata = '0;
                endcase
            end
        end
    end

    // read data and error held for the completing cycle
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_err;
        end
    end

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_irq = irq_ff;
endmodule : random_word_generator

// ---- sim/rng_chk.sv ----
`timescale 1ns/1ps
// port-level checks, all in the i_mclk domain
module rng_chk #(
    parameter int PERIOD = 84
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_irq
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // access phase still waiting, then a completing read of one offset
    sequence s_acc; i_psel && i_penable && !o_pready; endsequence
    sequence s_rd(a); o_pready && !i_pwrite && i_paddr == {24'h0, a}; endsequence
    chk_one_wait: assert property (s_acc |=> o_pready)
        else $error("ready late");
    chk_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready held");
    chk_ready_access: assert property (o_pready |-> i_psel && i_penable)
        else $error("stray ready");
    chk_err_ready: assert property (o_pslverr |-> o_pready)
        else $error("stray error");
    chk_err_unmapped: assert property (o_pready && i_paddr[31:8] != 0 |-> o_pslverr)
        else $error("unmapped accepted");
    chk_wo_zero: assert property (s_rd(rng_pkg::OFF_IRQ_ENABLE) |-> o_prdata == 0)
        else $error("write-only read nonzero");
    chk_mask_upper: assert property (s_rd(rng_pkg::OFF_IRQ_MASK) |-> !o_prdata[31:1])
        else $error("mask upper bits set");
    chk_flag_upper: assert property (s_rd(rng_pkg::OFF_IRQ_STATUS) |-> !o_prdata[31:1])
        else $error("status upper bits set");
endmodule : rng_chk

bind random_word_generator rng_chk #(.PERIOD(PERIOD)) i_rng_chk (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq));

// ---- sim/random_word_generator_test.sv ----
`timescale 1ns/1ps
module random_word_generator_test;
    logic i_mclk = '0, i_rst_n = '0, i_psel = '0, i_penable = '0, i_pwrite = '0;
    logic [31:0] i_paddr = '0, i_pwdata = '0, o_prdata, q, w1;
    logic o_pready, o_pslverr, o_irq, err;
    int num_errors = 0, checked = 0, n;
    time t1;
    random_word_generator i_random_word_generator (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq));
    initial forever #2 i_mclk = ~i_mclk;
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) num_errors++;
        if (g !== e) $display("Error at %0t: got %h exp %h", $time, g, e);
    endtask : chk
    task results();
        $display("errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    // a used-up wait counts as a mismatch and ends the run
    task tmo(input logic bad);
        if (bad) num_errors++;
        if (bad) results();
    endtask : tmo
    // one apb transfer; request held until pready is seen at an edge
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge i_mclk);
        i_psel <= 1'h1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'h1;
        k = 0;
        do @(posedge i_mclk); while (o_pready !== 1'h1 && ++k < 9);
        tmo(o_pready !== 1'h1);
        q = o_prdata;
        err = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
    endtask : apb
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, {24'h0, a}, '0);
        chk(q, e);
    endtask : rd
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, {24'h0, a}, d);
    endtask : wr
    // falling-edge count until the interrupt shows
    task wirq();
        n = 0;
        @(negedge i_mclk);
        while (o_irq !== 1'h1 && n < 400) begin
            @(negedge i_mclk);
            n++;
        end
        tmo(n >= 400);
    endtask : wirq
    initial begin
        n = $urandom(32'h6590);
        repeat (5) @(posedge i_mclk);
        i_rst_n <= 1'h1;
        rd(rng_pkg::OFF_IRQ_MASK, '0);
        rd(rng_pkg::OFF_IRQ_STATUS, '0);
        rd(rng_pkg::OFF_OUTPUT_WORD, rng_pkg::WORD_RESET);
        chk(32'(err), '0);
        apb(1'h0, {24'($urandom) | 24'h1, 8'h00}, '0);
        chk(32'(err), 32'h1);
        // zero in bit 0 must leave the mask alone
        wr(rng_pkg::OFF_IRQ_ENABLE, 32'($urandom) & 32'hFFFF_FFFE);
        rd(rng_pkg::OFF_IRQ_MASK, '0);
        wr(rng_pkg::OFF_IRQ_ENABLE, 32'h1);
        rd(rng_pkg::OFF_IRQ_MASK, 32'h1);
        wr(rng_pkg::OFF_IRQ_DISABLE, 32'($urandom) & 32'hFFFF_FFFE);
        rd(rng_pkg::OFF_IRQ_MASK, 32'h1);
        // random wrong key, generator must stay off
        wr(rng_pkg::OFF_CONTROL, {rng_pkg::KEY_VALUE ^ (24'($urandom) | 24'h1), 8'h01});
        // right key at an aliased address must be refused as well
        apb(1'h1, {24'($urandom) | 24'h1, rng_pkg::OFF_CONTROL}, {rng_pkg::KEY_VALUE, 8'h01});
        chk(32'(err), 32'h1);
        repeat (rng_pkg::WORD_PERIOD + 4) @(posedge i_mclk);
        rd(rng_pkg::OFF_IRQ_STATUS, '0);
        wr(rng_pkg::OFF_CONTROL, {rng_pkg::KEY_VALUE, 8'h01});
        wirq();
        chk(32'(n), rng_pkg::WORD_PERIOD);
        t1 = $time;
        rd(rng_pkg::OFF_IRQ_STATUS, 32'h1);
        @(negedge i_mclk);
        chk(32'(o_irq), '0);
        rd(rng_pkg::OFF_IRQ_STATUS, '0);
        apb(1'h0, {24'h0, rng_pkg::OFF_OUTPUT_WORD}, '0);
        w1 = q;
        chk(32'(w1 != '0), 32'h1);
        wirq();
        chk(32'(($time - t1) / 4), rng_pkg::WORD_PERIOD);
        apb(1'h0, {24'h0, rng_pkg::OFF_OUTPUT_WORD}, '0);
        chk(32'(q != w1), 32'h1);
        // masked: words still land but the line stays quiet
        wr(rng_pkg::OFF_IRQ_DISABLE, 32'h1);
        rd(rng_pkg::OFF_IRQ_MASK, '0);
        repeat (rng_pkg::WORD_PERIOD + 2) @(posedge i_mclk);
        chk(32'(o_irq), '0);
        rd(rng_pkg::OFF_IRQ_STATUS, 32'h1);
        wr(rng_pkg::OFF_CONTROL, {rng_pkg::KEY_VALUE, 8'h00});
        rd(rng_pkg::OFF_IRQ_STATUS, '0);
        repeat (rng_pkg::WORD_PERIOD + 4) @(posedge i_mclk);
        rd(rng_pkg::OFF_IRQ_STATUS, '0);
        results();
    end
endmodule : random_word_generator_test
